/* File: hdl/codec_status_gpio.sv */
// Status output and contact input logic of a networked audio codec
`timescale 1ns/100ps

// Overview of operation
// - Eight outputs, each with own mode
// - Asserted means contact closed to ground
// - Off mode: output never asserted
// - On mode: output asserted from the first clock out of reset
// - Far mirror: follow far input during call with compatible peer
// - Connected mode: asserted while call up
// - Receive locked: call, codec known, valid data
// - Loopback: output follows same local input
// - Dropped call: hold until redial or cancel
// - Packet loss: pulse on lost packet, retriggered by each further loss
// - Poor quality: bad packets over threshold
// - Poor quality re-evaluated every three seconds
// - Inputs from one source, outputs both
// - Items 1-4 channel 1, 5-8 channel 2
// - Fifth channel bit ignored both ways
// - Parallel inputs are active low
// - Net source configured selects network inputs
module codec_status_gpio
  import status_gpio_pkg::*;
#(
  parameter int PULSE_LEN   = PULSE_CYCLES,
  parameter int QUAL_PERIOD = QUAL_CYCLES
) (
  input  wire logic                  clk_in,
  input  wire logic                  reset_n_in,
  input  wire logic [N_BITS*MODE_W-1:0] mode_cfg_in,
  input  wire logic [ERRCNT_W-1:0]   qual_threshold_in,
  input  wire logic                  net_src_set_in,
  input  wire logic [N_BITS-1:0]     par_in_n_in,
  input  wire logic [CHAN_W-1:0]     net_status_in_channel_1_in,
  input  wire logic [CHAN_W-1:0]     net_status_in_channel_2_in,
  input  wire logic [N_BITS-1:0]     far_inputs_in,
  input  wire call_status_t          call_in,
  input  wire pkt_event_t            pkt_in,
  output logic [N_BITS-1:0]          par_out_n_out,
  output logic [CHAN_W-1:0]          net_status_out_channel_1_out,
  output logic [CHAN_W-1:0]          net_status_out_channel_2_out,
  output logic [N_BITS-1:0]          inputs_out
);

  localparam logic [TIMER_W-1:0] PULSE_LOAD =
    TIMER_W'(PULSE_LEN);
  localparam logic [TIMER_W-1:0] QUAL_LAST =
    TIMER_W'(QUAL_PERIOD - 1);

  gpio_state_t st_ff;
  gpio_state_t nxt_st;

  // Pack four status bits into a channel word, fifth bit left low
  function automatic logic [CHAN_W-1:0] to_chan(
    input logic [CHAN_USED-1:0] bits
  );
    to_chan = {1'b0, bits};
  endfunction

  function automatic out_mode_t mode_of(input int idx);
    logic [MODE_W-1:0] raw;
    raw = mode_cfg_in[idx*MODE_W +: MODE_W];
    if (raw > MODE_POOR_QUAL) begin
      mode_of = MODE_OFF;
    end else begin
      mode_of = out_mode_t'(raw);
    end
  endfunction

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Pick the live input source; the idle source is never looked at
  function automatic logic [N_BITS-1:0] pick_inputs(
    input logic              from_net,
    input logic [CHAN_W-1:0] chan_1,
    input logic [CHAN_W-1:0] chan_2,
    input logic [N_BITS-1:0] par_n
  );
    if (from_net) begin
      pick_inputs = {chan_2[CHAN_USED-1:0],
                     chan_1[CHAN_USED-1:0]};
    end else begin
      pick_inputs = ~par_n;
    end
  endfunction

  // Saturating add keeps a flood of bad packets from wrapping to zero
  function automatic logic [ERRCNT_W-1:0] sat_add(
    input logic [ERRCNT_W-1:0] base,
    input logic [ERRCNT_W-1:0] inc
  );
    if (base > ERRCNT_MAX - inc) begin
      sat_add = ERRCNT_MAX;
    end else begin
      sat_add = base + inc;
    end
  endfunction

  // Status of one output for the mode it is set to
  function automatic logic status_of(
    input out_mode_t    mode,
    input call_status_t call,
    input logic         far_bit,
    input logic         local_bit,
    input logic         dropped,
    input logic         pulse_on,
    input logic         poor
  );
    status_of = 1'b0;
    unique case (mode)
      MODE_OFF:        status_of = 1'b0;
      MODE_ON:         status_of = 1'b1;
      far_mirror_mode: status_of = call.call_up && call.peer_compat &&
                                   far_bit;
      MODE_CONNECTED:  status_of = call.call_up;
      MODE_RX_LOCKED:  status_of = call.call_up && call.codec_known &&
                                   call.rx_valid;
      MODE_LOOPBACK:   status_of = local_bit;
      MODE_DROPPED:    status_of = dropped;
      MODE_PKT_LOSS:   status_of = pulse_on;
      MODE_POOR_QUAL:  status_of = poor;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [N_BITS-1:0]   in_now;
    logic [ERRCNT_W-1:0] bad_inc;
    logic                pulse_on;
    nxt_st   = st_ff;
    in_now   = BITS_ZERO;
    bad_inc  = ERRCNT_ZERO;
    pulse_on = 1'b0;

    // ----------------------------------------------------------
    // Input source
    // ----------------------------------------------------------
    // Network word bit 4 is dropped here, so it can never leak in
    in_now = pick_inputs(net_src_set_in, net_status_in_channel_1_in,
                         net_status_in_channel_2_in,
                         par_in_n_in);
    nxt_st.inputs = in_now;

    // ----------------------------------------------------------
    // Dropped call latch
    // ----------------------------------------------------------
    // A new drop wins over a clear in the same cycle
    if (call_in.call_dropped) begin
      nxt_st.dropped = 1'b1;
    end else if (call_in.call_restored || call_in.redial_cancel) begin
      nxt_st.dropped = 1'b0;
    end

    // ----------------------------------------------------------
    // Packet loss pulse
    // ----------------------------------------------------------
    // Loss pulse retriggers so a burst reads as one long closure
    if (pkt_in.pkt_lost) begin
      nxt_st.pulse_cnt = PULSE_LOAD;
    end else if (st_ff.pulse_cnt != TIMER_ZERO) begin
      nxt_st.pulse_cnt = st_ff.pulse_cnt - 1'b1;
    end
    pulse_on = (st_ff.pulse_cnt != TIMER_ZERO);

    // ----------------------------------------------------------
    // Quality window
    // ----------------------------------------------------------
    // One lost and one errored packet in a cycle count two
    bad_inc = ERRCNT_W'(pkt_in.pkt_lost) + ERRCNT_W'(pkt_in.pkt_errored);
    nxt_st.bad_cnt = sat_add(st_ff.bad_cnt, bad_inc);
    if (st_ff.qual_cnt == QUAL_LAST) begin
      nxt_st.qual_cnt = TIMER_ZERO;
      nxt_st.poor     = (st_ff.bad_cnt > qual_threshold_in);
      // The new window opens with this cycle's events
      nxt_st.bad_cnt  = sat_add(ERRCNT_ZERO, bad_inc);
    end else begin
      nxt_st.qual_cnt = st_ff.qual_cnt + 1'b1;
    end

    // ----------------------------------------------------------
    // Status per output
    // ----------------------------------------------------------
    for (int i = 0; i < N_BITS; i++) begin
      nxt_st.status[i] = status_of(mode_of(i), call_in, far_inputs_in[i],
                                   st_ff.inputs[i], st_ff.dropped,
                                   pulse_on, st_ff.poor);
    end

    // ----------------------------------------------------------
    // Output mapping
    // ----------------------------------------------------------
    // Outputs are closures to ground, presented on both interfaces
    nxt_st.par_out_n = ~nxt_st.status;
    nxt_st.net_status_out_channel_1 =
      to_chan(nxt_st.status[CHAN_USED-1:0]);
    nxt_st.net_status_out_channel_2 =
      to_chan(nxt_st.status[N_BITS-1:CHAN_USED]);
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      st_ff           <= '0;
      st_ff.par_out_n <= ~BITS_ZERO;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign par_out_n_out                = st_ff.par_out_n;
  assign net_status_out_channel_1_out = st_ff.net_status_out_channel_1;
  assign net_status_out_channel_2_out = st_ff.net_status_out_channel_2;
  assign inputs_out                   = st_ff.inputs;

endmodule

/* File: hdl/status_gpio_pkg.sv */
// Package: constants, modes and carriers for the codec status GPIO block
package status_gpio_pkg;

  localparam int          N_BITS          = 8;
  localparam int          CHAN_W          = 5;
  localparam int          CHAN_USED       = 4;
  localparam int          MODE_W          = 4;
  localparam int          CLK_HZ          = 100_000_000;
  localparam int          QUAL_PERIOD_S   = 3;
  localparam int          QUAL_CYCLES     = QUAL_PERIOD_S * CLK_HZ;
  localparam int          PULSE_CYCLES    = 5_000_000;
  localparam int          TIMER_W         = 32;
  localparam int          ERRCNT_W        = 16;
  localparam logic [TIMER_W-1:0] TIMER_ZERO = 32'h0000_0000;
  localparam logic [ERRCNT_W-1:0] ERRCNT_ZERO = 16'h0000;
  localparam logic [ERRCNT_W-1:0] ERRCNT_MAX  = 16'hFFFF;
  localparam logic [N_BITS-1:0] BITS_ZERO   = 8'h00;
  localparam logic [CHAN_W-1:0] CHAN_ZERO   = 5'h00;

  typedef enum logic [MODE_W-1:0] {
    MODE_OFF        = 4'h0,
    MODE_ON         = 4'h1,
    far_mirror_mode = 4'h2,
    MODE_CONNECTED  = 4'h3,
    MODE_RX_LOCKED  = 4'h4,
    MODE_LOOPBACK   = 4'h5,
    MODE_DROPPED    = 4'h6,
    MODE_PKT_LOSS   = 4'h7,
    MODE_POOR_QUAL  = 4'h8
  } out_mode_t;

  // Call status as reported by the call controller
  typedef struct packed {
    logic call_up;
    logic peer_compat;
    logic codec_known;
    logic rx_valid;
    logic call_dropped;
    logic call_restored;
    logic redial_cancel;
  } call_status_t;

  typedef struct packed {
    logic pkt_lost;
    logic pkt_errored;
  } pkt_event_t;

  typedef struct packed {
    logic [N_BITS-1:0]   par_out_n;
    logic [CHAN_W-1:0]   net_status_out_channel_1;
    logic [CHAN_W-1:0]   net_status_out_channel_2;
    logic [N_BITS-1:0]   status;
    logic [N_BITS-1:0]   inputs;
    logic                dropped;
    logic                poor;
    logic [TIMER_W-1:0]  pulse_cnt;
    logic [TIMER_W-1:0]  qual_cnt;
    logic [ERRCNT_W-1:0] bad_cnt;
  } gpio_state_t;

endpackage

/* File: tb/codec_status_gpio_tb_top.sv */
// Self-checking bench of the status GPIO block
`timescale 1ns/100ps
module codec_status_gpio_tb_top;
  import status_gpio_pkg::*;
  logic clk_in = 1'b0, reset_n_in = 1'b0, net_src_set_in = 1'b0;
  logic [31:0] mode_cfg_in = 32'h0000_0008, rnd = 32'h7185F7F9;
  logic [15:0] qual_threshold_in = 16'h0002;
  logic [7:0]  closed = 8'h00, far_inputs_in = 8'h00, par_in_n_in, inp, st;
  logic [7:0]  par_out_n_out, inputs_out;
  logic [4:0]  net_status_in_channel_1_in = 5'h00;
  logic [4:0]  net_status_in_channel_2_in = 5'h00;
  logic [4:0]  net_status_out_channel_1_out, net_status_out_channel_2_out;
  call_status_t call_in = '0;
  pkt_event_t  pkt_in = '0;
  logic [25:0] q_v[$];
  int q_t[$], cyc = 0, n_fail = 0, n_compared = 0;
  wire [25:0] seen = {par_out_n_out, net_status_out_channel_1_out,
                      net_status_out_channel_2_out, inputs_out};
  codec_status_gpio #(.PULSE_LEN(4), .QUAL_PERIOD(20)) dut (.*);
  contact_model contacts (.closed_in(closed), .par_n_out(par_in_n_in));
  initial forever #5 clk_in = ~clk_in;
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Expected snapshot is checked at the next falling edge
  task automatic note(logic [7:0] s, logic [7:0] i);
    q_t.push_back(cyc + 1);
    q_v.push_back({~s, 1'b0, s[3:0], 1'b0, s[7:4], i});
  endtask
  task automatic compare(logic [25:0] e, logic [25:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("BAD outputs exp %h got %h", e, g);
    end
  endtask
  task automatic close_out();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk_in);
  endtask
  always @(posedge clk_in) cyc <= cyc + 1;
  always @(negedge clk_in) begin
    if (q_t.size() > 0 && q_t[0] == cyc) begin
      void'(q_t.pop_front());
      compare(q_v.pop_front(), seen);
    end
    if (cyc > 500) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    tick(2);
    reset_n_in <= 1'b1;
    note(8'h00, 8'h00);
    pkt_in <= 2'b11;
    tick(1);
    pkt_in <= 2'b10;
    tick(1);
    pkt_in <= 2'b00;
    tick(26);
    note(8'h01, 8'h00);
    pkt_in <= 2'b11;
    tick(1);
    pkt_in <= 2'b00;
    tick(22);
    note(8'h00, 8'h00);
    mode_cfg_in <= 32'h0000_0076;
    for (int k = 0; k < 2; k++) begin
      call_in.call_dropped <= 1'b1;
      tick(1);
      call_in.call_dropped <= 1'b0;
      tick(3);
      note(8'h01, 8'h00);
      if (k == 0) call_in.call_restored <= 1'b1;
      else call_in.redial_cancel <= 1'b1;
      tick(1);
      call_in <= '0;
      tick(2);
      note(8'h00, 8'h00);
      pkt_in <= 2'b10;
      tick(1);
      pkt_in <= 2'b00;
      tick(2 + 2 * k);
      note(8'h02, 8'h00);
    end
    tick(6);
    note(8'h00, 8'h00);
    mode_cfg_in <= 32'hF954_3210;
    repeat (24) begin
      rnd = nxt(rnd);
      closed <= rnd[7:0];
      far_inputs_in <= rnd[15:8];
      net_status_in_channel_1_in <= rnd[20:16];
      net_status_in_channel_2_in <= rnd[25:21];
      net_src_set_in <= rnd[26];
      call_in <= {rnd[30:27], 3'b000};
      tick(3);
      inp = rnd[26] ? {rnd[24:21], rnd[19:16]} : rnd[7:0];
      st = {2'b00, inp[5], rnd[30] & rnd[28] & rnd[27], rnd[30],
            rnd[30] & rnd[29] & rnd[10], 2'b10};
      note(st, inp);
    end
    tick(2);
    close_out();
  end
endmodule

/* File: tb/contact_model.sv */
// Switch contacts on the parallel input pins
`timescale 1ns/100ps
module contact_model (
  input  wire logic [7:0] closed_in,
  output logic      [7:0] par_n_out
);
  // Closed shorts to ground, open floats to the pull-up
  assign par_n_out = ~closed_in;
endmodule

/* File: tb/status_gpio_monitor.sv */
// Port checker of the status GPIO block
`timescale 1ns/100ps
module status_gpio_monitor
  import status_gpio_pkg::*;
#(parameter int PULSE_LEN = 4) (
  input wire logic         clk_in, reset_n_in, net_src_set_in,
  input wire logic [31:0]  mode_cfg_in,
  input wire logic [7:0]   par_in_n_in, far_inputs_in, inputs_out,
  input wire logic [7:0]   par_out_n_out,
  input wire logic [4:0]   net_status_in_channel_1_in,
  input wire logic [4:0]   net_status_in_channel_2_in,
  input wire logic [4:0]   net_status_out_channel_1_out,
  input wire logic [4:0]   net_status_out_channel_2_out,
  input wire call_status_t call_in,
  input wire pkt_event_t   pkt_in
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  wire [7:0] st = ~par_out_n_out;
  wire [4:0] o1 = net_status_out_channel_1_out;
  wire [4:0] o2 = net_status_out_channel_2_out;
  sequence loss_s; ##2 st[1] [*3]; endsequence
  off_hold_a: assert property (mode_cfg_in[3:0] == 4'h0 |=> !st[0])
    else $error("off output set");
  on_hold_a: assert property (mode_cfg_in[7:4] == 4'h1 |=> st[1])
    else $error("on output clear");
  far_follow_a: assert property (mode_cfg_in[11:8] == 4'h2 &&
    call_in.call_up && call_in.peer_compat |=> st[2] == $past(far_inputs_in[2]))
    else $error("mirror wrong");
  call_up_a: assert property (mode_cfg_in[15:12] == 4'h3
    |=> st[3] == $past(call_in.call_up)) else $error("connected wrong");
  rx_lock_a: assert property (mode_cfg_in[19:16] == 4'h4 |=> st[4] ==
    $past(call_in.call_up & call_in.codec_known & call_in.rx_valid))
    else $error("locked wrong");
  loop_follow_a: assert property (mode_cfg_in[23:20] == 4'h5
    |=> st[5] == $past(inputs_out[5])) else $error("loopback wrong");
  spare_code_a: assert property (mode_cfg_in[27:24] > 4'h8 |=> !st[6])
    else $error("spare mode set");
  drop_set_a: assert property (mode_cfg_in[3:0] == 4'h6 &&
    call_in.call_dropped |-> ##2 st[0]) else $error("drop not latched");
  loss_pulse_a: assert property (mode_cfg_in[7:4] == 4'h7 &&
    pkt_in.pkt_lost |-> loss_s) else $error("loss pulse short");
  chan_copy_a: assert property ({o2[3:0], o1[3:0]} == st && !o1[4] &&
    !o2[4]) else $error("channel copy wrong");
  in_select_a: assert property (1'b1 |=> inputs_out == $past(net_src_set_in ?
    {net_status_in_channel_2_in[3:0], net_status_in_channel_1_in[3:0]} :
    ~par_in_n_in)) else $error("input source wrong");
endmodule

bind codec_status_gpio status_gpio_monitor #(.PULSE_LEN(PULSE_LEN)) mon (.*);
